// file: pmtr_pkg.sv
// ****************************************************************
// Telemetry read-back constants
// ****************************************************************
package pmtr_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_VIN   = 8'h88; // Input voltage
  localparam logic [7:0] CMD_IIN   = 8'h89; // Input current
  localparam logic [7:0] CMD_VOUT  = 8'h8b; // Output voltage, code word
  localparam logic [7:0] CMD_IOUT  = 8'h8c; // Output current
  localparam logic [7:0] CMD_TEMP  = 8'h8d; // Temperature
  localparam logic [7:0] CMD_POUT  = 8'h96; // Output power
  localparam logic [7:0] CMD_PIN   = 8'h97; // Input power
  localparam logic [7:0] CMD_REV   = 8'h98; // Protocol revision
  localparam logic [7:0] CMD_MAKER = 8'h99; // Maker identification
  localparam logic [7:0] CMD_MODEL = 8'h9a; // Model identification

  // ****************************************************************
  // Field layout of a linear word
  // ****************************************************************
  localparam int EXP_MSB = 15; // Exponent top bit
  localparam int EXP_LSB = 11; // Exponent bottom bit
  localparam int MAN_MSB = 10; // Mantissa top bit
  localparam int MAN_LSB = 0;  // Mantissa bottom bit
  localparam int EXP_W   = EXP_MSB - EXP_LSB + 1; // 5 bits
  localparam int MAN_W   = MAN_MSB - MAN_LSB + 1; // 11 bits
  localparam int WORD_W  = 16;                    // Register word width

  // ****************************************************************
  // Fixed values and reset values
  // ****************************************************************
  localparam logic [7:0]  PROTOCOL_REV_VAL = 8'h11;  // Revision 1.1
  localparam logic [15:0] WORD_RESET       = 16'h0000; // Telemetry reset
  localparam logic [7:0]  BYTE_RESET       = 8'h00;  // Byte reset
  localparam int          MEM_FAULT_BIT    = 4;      // Memory error flag

  // ****************************************************************
  // Telemetry slot numbering
  // ****************************************************************
  localparam int N_LIN    = 6; // Linear quantities
  localparam int SLOT_VIN = 0;
  localparam int SLOT_IIN = 1;
  localparam int SLOT_IOUT = 2;
  localparam int SLOT_TEMP = 3;
  localparam int SLOT_POUT = 4;
  localparam int SLOT_PIN  = 5;

  // Upper-byte store targets
  typedef enum logic {
    PMTR_SEL_MAKER = 1'b0,
    PMTR_SEL_MODEL = 1'b1
  } pmtr_sel_type;

endpackage : pmtr_pkg

// file: pmtr_regs.sv
// Function
// - Linear word exponent in bits 15:11
// - Linear word mantissa in bits 10:0
// - Code 88h reads input voltage, linear
// - Code 89h reads input current, linear
// - Code 8Bh reads output voltage code word
// - Code 8Ch reads output current, linear
// - Code 8Dh reads temperature, linear
// - Code 96h reads output power, linear
// - Code 97h reads input power, linear
// - Code 98h reads fixed revision 11h
// - Code 99h maker word, upper byte writable
// - Code 9Ah model word, upper byte writable
// - Write during memory programming latches bit 4
`timescale 1ns/1ps
`default_nettype none

module pmtr_regs #(
  parameter logic [7:0] MAKER_FIXED_BYTE = 8'h5a, // Arbitrary value
  parameter logic [7:0] MODEL_FIXED_BYTE = 8'h3c  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  // Linear telemetry, exponent and mantissa
  input  wire logic [4:0]  vin_scale_field,
  input  wire logic [10:0] vin_mant,
  input  wire logic [4:0]  iin_exp,
  input  wire logic [10:0] iin_mant,
  input  wire logic [4:0]  iout_exp,
  input  wire logic [10:0] iout_mant,
  input  wire logic [4:0]  temp_exp,
  input  wire logic [10:0] temp_mant,
  input  wire logic [4:0]  pout_exp,
  input  wire logic [10:0] pout_mant,
  input  wire logic [4:0]  pin_exp,
  input  wire logic [10:0] pin_mant,
  // Output voltage code word
  input  wire logic [15:0] vout_code_field,
  // Non-volatile memory side
  input  wire logic        nvm_busy,
  input  wire logic [7:0]  nvm_maker_init,
  input  wire logic [7:0]  nvm_model_init,
  output logic             nvm_store_pulse,
  output logic             nvm_store_sel,
  output logic [7:0]       nvm_store_byte,
  // Memory status
  input  wire logic        mem_fault_clear,
  output logic [7:0]       mem_status
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Pack exponent and mantissa into one linear word
  function automatic logic [15:0] pack_linear(
    input logic [4:0]  exp_in,
    input logic [10:0] man_in
  );
    logic [15:0] word;
    word = pmtr_pkg::WORD_RESET;
    word[pmtr_pkg::EXP_MSB:pmtr_pkg::EXP_LSB] = exp_in;
    word[pmtr_pkg::MAN_MSB:pmtr_pkg::MAN_LSB] = man_in;
    return word;
  endfunction

  // True for codes that hold only read-only content
  function automatic logic is_read_only(input logic [7:0] code);
    case (code)
      pmtr_pkg::CMD_VIN, pmtr_pkg::CMD_IIN, pmtr_pkg::CMD_VOUT,
      pmtr_pkg::CMD_IOUT, pmtr_pkg::CMD_TEMP, pmtr_pkg::CMD_POUT,
      pmtr_pkg::CMD_PIN, pmtr_pkg::CMD_REV: is_read_only = 1'b1;
      default: is_read_only = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Telemetry capture
  // ****************************************************************
  logic [4:0]  exp_in   [pmtr_pkg::N_LIN]; // Exponent per slot
  logic [10:0] man_in   [pmtr_pkg::N_LIN]; // Mantissa per slot
  logic [15:0] lin_reg  [pmtr_pkg::N_LIN]; // Packed words
  logic [15:0] lin_next [pmtr_pkg::N_LIN];
  logic [15:0] vout_reg;                   // Output voltage code
  logic [15:0] vout_next;

  // Slot assignment of the measurement inputs
  assign exp_in[pmtr_pkg::SLOT_VIN]  = vin_scale_field;
  assign man_in[pmtr_pkg::SLOT_VIN]  = vin_mant;
  assign exp_in[pmtr_pkg::SLOT_IIN]  = iin_exp;
  assign man_in[pmtr_pkg::SLOT_IIN]  = iin_mant;
  assign exp_in[pmtr_pkg::SLOT_IOUT] = iout_exp;
  assign man_in[pmtr_pkg::SLOT_IOUT] = iout_mant;
  assign exp_in[pmtr_pkg::SLOT_TEMP] = temp_exp;
  assign man_in[pmtr_pkg::SLOT_TEMP] = temp_mant;
  assign exp_in[pmtr_pkg::SLOT_POUT] = pout_exp;
  assign man_in[pmtr_pkg::SLOT_POUT] = pout_mant;
  assign exp_in[pmtr_pkg::SLOT_PIN]  = pin_exp;
  assign man_in[pmtr_pkg::SLOT_PIN]  = pin_mant;

  // One capture register per linear quantity; the host sees a
  // value one cycle old, which keeps the read path register-fed
  genvar gi;
  generate
    for (gi = 0; gi < pmtr_pkg::N_LIN; gi++) begin : g_lin
      always_comb begin
        lin_next[gi] = pack_linear(exp_in[gi], man_in[gi]);
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          lin_reg[gi] <= pmtr_pkg::WORD_RESET;
        end else begin
          lin_reg[gi] <= lin_next[gi];
        end
      end
    end
  endgenerate

  // Code word taken whole, all sixteen bits
  always_comb begin
    vout_next = vout_code_field;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vout_reg <= pmtr_pkg::WORD_RESET;
    end else begin
      vout_reg <= vout_next;
    end
  end

  // ****************************************************************
  // Command decode, identity bytes and memory status
  // ****************************************************************
  logic        wr_cmd;          // Write command this cycle
  logic        rd_cmd;          // Read command this cycle
  logic        id_write;        // Write to an identity code
  logic        load_done_reg;   // Identity bytes loaded after reset
  logic        load_done_next;
  logic [7:0]  maker_hi_reg;    // Writable maker byte
  logic [7:0]  maker_hi_next;
  logic [7:0]  model_hi_reg;    // Writable model byte
  logic [7:0]  model_hi_next;
  logic        fault_reg;       // Sticky memory error
  logic        fault_next;
  logic        store_reg;       // Store request to memory
  logic        store_next;
  logic        sel_reg;         // Which byte to store
  logic        sel_next;
  logic [7:0]  sbyte_reg;       // Byte to store
  logic [7:0]  sbyte_next;
  logic        rvalid_reg;      // Read answer valid
  logic        rvalid_next;
  logic [15:0] rdata_reg;       // Read answer data
  logic [15:0] rdata_next;

  assign wr_cmd   = cmd_valid && cmd_write;
  assign rd_cmd   = cmd_valid && !cmd_write;
  assign id_write = wr_cmd && !is_read_only(cmd_code) &&
                    (cmd_code == pmtr_pkg::CMD_MAKER ||
                     cmd_code == pmtr_pkg::CMD_MODEL);

  // Next state of identity bytes, fault flag and answers
  always_comb begin
    load_done_next = 1'b1;
    maker_hi_next  = maker_hi_reg;
    model_hi_next  = model_hi_reg;
    fault_next     = fault_reg;
    store_next     = 1'b0;
    sel_next       = sel_reg;
    sbyte_next     = sbyte_reg;
    rvalid_next    = rd_cmd;
    rdata_next     = rdata_reg;
    // Stored bytes are caught after reset release, never under it
    if (!load_done_reg) begin
      maker_hi_next = nvm_maker_init;
      model_hi_next = nvm_model_init;
    end
    // Clear first so that a new error in the same cycle wins
    if (mem_fault_clear) begin
      fault_next = 1'b0;
    end
    if (wr_cmd && nvm_busy) begin
      fault_next = 1'b1;
    end else if (id_write && load_done_reg) begin
      // Writes to read-only codes fall through untouched
      store_next = 1'b1;
      sbyte_next = cmd_wdata[15:8];
      if (cmd_code == pmtr_pkg::CMD_MAKER) begin
        maker_hi_next = cmd_wdata[15:8];
        sel_next      = pmtr_pkg::PMTR_SEL_MAKER;
      end else begin
        model_hi_next = cmd_wdata[15:8];
        sel_next      = pmtr_pkg::PMTR_SEL_MODEL;
      end
    end
    // Read mux
    if (rd_cmd) begin
      case (cmd_code)
        pmtr_pkg::CMD_VIN:   rdata_next = lin_reg[pmtr_pkg::SLOT_VIN];
        pmtr_pkg::CMD_IIN:   rdata_next = lin_reg[pmtr_pkg::SLOT_IIN];
        pmtr_pkg::CMD_VOUT:  rdata_next = vout_reg;
        pmtr_pkg::CMD_IOUT:  rdata_next = lin_reg[pmtr_pkg::SLOT_IOUT];
        pmtr_pkg::CMD_TEMP:  rdata_next = lin_reg[pmtr_pkg::SLOT_TEMP];
        pmtr_pkg::CMD_POUT:  rdata_next = lin_reg[pmtr_pkg::SLOT_POUT];
        pmtr_pkg::CMD_PIN:   rdata_next = lin_reg[pmtr_pkg::SLOT_PIN];
        pmtr_pkg::CMD_REV:   rdata_next = {pmtr_pkg::BYTE_RESET,
                                pmtr_pkg::PROTOCOL_REV_VAL};
        pmtr_pkg::CMD_MAKER: rdata_next = {maker_hi_reg,
                                MAKER_FIXED_BYTE};
        pmtr_pkg::CMD_MODEL: rdata_next = {model_hi_reg,
                                MODEL_FIXED_BYTE};
        // Unmapped codes answer with zero
        default:             rdata_next = pmtr_pkg::WORD_RESET;
      endcase
    end
  end

  // Register stage for the command side
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      load_done_reg <= 1'b0;
      maker_hi_reg  <= pmtr_pkg::BYTE_RESET;
      model_hi_reg  <= pmtr_pkg::BYTE_RESET;
      fault_reg     <= 1'b0;
      store_reg     <= 1'b0;
      sel_reg       <= 1'b0;
      sbyte_reg     <= pmtr_pkg::BYTE_RESET;
      rvalid_reg    <= 1'b0;
      rdata_reg     <= pmtr_pkg::WORD_RESET;
    end else begin
      load_done_reg <= load_done_next;
      maker_hi_reg  <= maker_hi_next;
      model_hi_reg  <= model_hi_next;
      fault_reg     <= fault_next;
      store_reg     <= store_next;
      sel_reg       <= sel_next;
      sbyte_reg     <= sbyte_next;
      rvalid_reg    <= rvalid_next;
      rdata_reg     <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign rsp_valid       = rvalid_reg;
  assign rsp_data        = rdata_reg;
  assign nvm_store_pulse = store_reg;
  assign nvm_store_sel   = sel_reg;
  assign nvm_store_byte  = sbyte_reg;
  assign mem_status      = {3'h0, fault_reg, 4'h0};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Read of a code at one edge
  sequence s_read(logic [7:0] code);
    rd_cmd && cmd_code == code;
  endsequence

  // Write while programming is in progress
  sequence s_busy_write;
    wr_cmd && nvm_busy;
  endsequence

  a_vin_linear: assert property (
    s_read(pmtr_pkg::CMD_VIN) |=> rsp_valid &&
      rsp_data == {$past(vin_scale_field, 2), $past(vin_mant, 2)})
    else $error("input voltage word wrong");
  a_iin_exponent: assert property (
    s_read(pmtr_pkg::CMD_IIN) |=> rsp_data[15:11] == $past(iin_exp, 2))
    else $error("input current exponent wrong");
  a_iout_mantissa: assert property (
    s_read(pmtr_pkg::CMD_IOUT) |=> rsp_data[10:0] == $past(iout_mant, 2))
    else $error("output current mantissa wrong");
  a_vout_code: assert property (
    s_read(pmtr_pkg::CMD_VOUT) |=> rsp_data == $past(vout_code_field, 2))
    else $error("output voltage code wrong");
  a_temp_word: assert property (
    s_read(pmtr_pkg::CMD_TEMP) |=>
      rsp_data == {$past(temp_exp, 2), $past(temp_mant, 2)})
    else $error("temperature word wrong");
  a_power_words: assert property (
    s_read(pmtr_pkg::CMD_POUT) ##1 s_read(pmtr_pkg::CMD_PIN) |->
      rsp_data == {$past(pout_exp, 2), $past(pout_mant, 2)} ##1
      rsp_data == {$past(pin_exp, 2), $past(pin_mant, 2)})
    else $error("power words wrong");
  a_rev_fixed: assert property (
    s_read(pmtr_pkg::CMD_REV) |=> rsp_valid && rsp_data == 16'h0011)
    else $error("revision byte wrong");
  a_model_store: assert property (
    load_done_reg && !nvm_busy && wr_cmd &&
    cmd_code == pmtr_pkg::CMD_MODEL ##1 s_read(pmtr_pkg::CMD_MODEL) |=>
      rsp_data == {$past(cmd_wdata[15:8], 2), MODEL_FIXED_BYTE})
    else $error("model byte not stored");
  a_maker_fixed: assert property (
    s_read(pmtr_pkg::CMD_MAKER) |=> rsp_data[7:0] == MAKER_FIXED_BYTE)
    else $error("maker fixed byte wrong");
  a_fault_latch: assert property (
    s_busy_write |=> mem_status[4] && !nvm_store_pulse
      ##1 (mem_status[4] || $past(mem_fault_clear)))
    else $error("memory error not latched");
  a_ro_ignored: assert property (
    wr_cmd && is_read_only(cmd_code) |=>
      !nvm_store_pulse && $stable(maker_hi_reg) && $stable(model_hi_reg))
    else $error("read-only write had effect");
  a_no_write_answer: assert property (
    wr_cmd |=> !rsp_valid)
    else $error("write produced an answer");

endmodule // pmtr_regs

`default_nettype wire

// file: pmtr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host side of the command port
// ****************************************************************
module pmtr_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Command port toward the register bank
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data
);

  // Quiet bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // One command per call; caller enters just after a rising edge
  // Back-to-back calls keep cmd_valid high, one command per cycle
  task automatic send(input logic wr, input logic [7:0] code,
                      input logic [15:0] wd, output logic rv,
                      output logic [15:0] rd);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code  = code;
    // Only the upper byte carries meaning on writes
    cmd_wdata = wr ? wd : ~cmd_wdata;
    @(posedge clk_sys);
    #1;
    rv = rsp_valid;
    rd = rsp_data;
  endtask

  // Release the port; qualifiers change so stale values mean nothing
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_write = ~cmd_write;
    cmd_code  = ~cmd_code;
    @(posedge clk_sys);
    #1;
  endtask

endmodule // pmtr_host_model

`default_nettype wire

// file: pmtr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Testbench for the telemetry read-back bank
// ****************************************************************
module pmtr_regs_tb_top;

  // Read row: command code beside the word it should return
  typedef struct {
    logic [7:0]  code;
    logic [15:0] want;
  } pmtr_row_type;

  logic        clk_sys = 1'b0;    // 250 MHz system clock
  logic        rst_b   = 1'b0;    // Synchronous reset, low active
  logic        cmd_valid, cmd_write, rsp_valid;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, rsp_data;
  logic [4:0]  vin_e = 5'h1b, iin_e = 5'h02, iout_e = 5'h1f;
  logic [4:0]  temp_e = 5'h00, pout_e = 5'h10, pin_e = 5'h0f;
  logic [10:0] vin_m = 11'h123, iin_m = 11'h7ff, iout_m = 11'h400;
  logic [10:0] temp_m = 11'h019, pout_m = 11'h001, pin_m = 11'h555;
  logic [15:0] vout_w = 16'ha5c3; // Code word, all 16 bits used
  logic        nvm_busy = 1'b0, mem_fault_clear = 1'b0;
  logic        nvm_store_pulse, nvm_store_sel;
  logic [7:0]  nvm_store_byte, mem_status;
  logic        rv;
  logic [15:0] rd;
  int          err_total = 0, num_checks = 0;
  pmtr_row_type rows [11];

  // Clock: 4 ns period
  always #2 clk_sys = ~clk_sys;

  // ****************************************************************
  // Design and host model
  // ****************************************************************
  pmtr_regs u_pmtr_regs (
    .clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .vin_scale_field(vin_e), .vin_mant(vin_m), .iin_exp(iin_e),
    .iin_mant(iin_m), .iout_exp(iout_e), .iout_mant(iout_m),
    .temp_exp(temp_e), .temp_mant(temp_m), .pout_exp(pout_e),
    .pout_mant(pout_m), .pin_exp(pin_e), .pin_mant(pin_m),
    .vout_code_field(vout_w), .nvm_busy(nvm_busy),
    .nvm_maker_init(8'hc4), .nvm_model_init(8'h7e),
    .nvm_store_pulse(nvm_store_pulse), .nvm_store_sel(nvm_store_sel),
    .nvm_store_byte(nvm_store_byte), .mem_fault_clear(mem_fault_clear),
    .mem_status(mem_status));

  pmtr_host_model u_pmtr_host_model (
    .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  // Compare one word; four-state equality so X never matches
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Read every row back to back and compare answer and strobe
  task automatic run_rows();
    foreach (rows[i]) begin
      u_pmtr_host_model.send(1'b0, rows[i].code, 16'h0000, rv, rd);
      chk({15'h0000, rv}, 16'h0001);
      chk(rd, rows[i].want);
    end
    u_pmtr_host_model.idle();
  endtask

  // Identity write, store strobe, then read back next cycle
  task automatic id_write(input logic [7:0] code, input logic [7:0] b,
                          input logic sel, input logic [7:0] fx);
    u_pmtr_host_model.send(1'b1, code, {b, 8'h0f}, rv, rd);
    chk({6'h00, nvm_store_pulse, nvm_store_sel, nvm_store_byte},
        {6'h00, 1'b1, sel, b});
    u_pmtr_host_model.send(1'b0, code, 16'h0000, rv, rd);
    chk(rd, {b, fx});
  endtask

  // Watchdog: the whole sequence needs well under 500 cycles
  initial begin
    #20000;
    err_total++;
    end_sim();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rows[0] = '{8'h88, {vin_e, vin_m}};
    rows[1] = '{8'h89, {iin_e, iin_m}};
    rows[2] = '{8'h8b, vout_w};
    rows[3] = '{8'h8c, {iout_e, iout_m}};
    rows[4] = '{8'h8d, {temp_e, temp_m}};
    rows[5] = '{8'h96, {pout_e, pout_m}};
    rows[6] = '{8'h97, {pin_e, pin_m}};
    rows[7] = '{8'h98, 16'h0011};
    rows[8] = '{8'h99, 16'hc45a};
    rows[9] = '{8'h9a, 16'h7e3c};
    rows[10] = '{8'h9b, 16'h0000};         // Unmapped code reads zero
    repeat (16) @(posedge clk_sys);
    #1;
    chk({6'h00, rsp_valid, nvm_store_pulse, mem_status}, 16'h0000);
    rst_b = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    run_rows();
    id_write(8'h99, 8'hab, 1'b0, 8'h5a);
    id_write(8'h9a, 8'h61, 1'b1, 8'h3c);
    rows[8].want = 16'hab5a;
    rows[9].want = 16'h613c;
    // Writes to read-only and unmapped codes must change nothing
    for (int i = 0; i < 8; i++) begin
      u_pmtr_host_model.send(1'b1, rows[i].code, 16'hffff, rv, rd);
      chk({15'h0000, nvm_store_pulse}, 16'h0000);
    end
    u_pmtr_host_model.send(1'b1, 8'hb0, 16'h1200, rv, rd);
    chk({15'h0000, nvm_store_pulse}, 16'h0000);
    u_pmtr_host_model.idle();
    run_rows();
    // Write during memory programming: dropped and flagged
    nvm_busy = 1'b1;
    u_pmtr_host_model.send(1'b1, 8'h99, 16'h3300, rv, rd);
    chk({7'h00, nvm_store_pulse, mem_status}, 16'h0010);
    nvm_busy = 1'b0;
    u_pmtr_host_model.idle();
    chk({8'h00, mem_status}, 16'h0010);
    u_pmtr_host_model.send(1'b0, 8'h99, 16'h0000, rv, rd);
    chk(rd, 16'hab5a);
    mem_fault_clear = 1'b1;
    u_pmtr_host_model.idle();
    mem_fault_clear = 1'b0;
    chk({8'h00, mem_status}, 16'h0000);
    // Telemetry follows its inputs, negative mantissa included
    vin_m = 11'h6aa;
    vin_e = 5'h01;
    u_pmtr_host_model.idle();
    u_pmtr_host_model.send(1'b0, 8'h88, 16'h0000, rv, rd);
    chk(rd, 16'h0eaa);
    u_pmtr_host_model.idle();
    // Error and clear in one cycle: the error must win
    nvm_busy = 1'b1;
    mem_fault_clear = 1'b1;
    u_pmtr_host_model.send(1'b1, 8'h9a, 16'h4400, rv, rd);
    chk({7'h00, nvm_store_pulse, mem_status}, 16'h0010);
    nvm_busy = 1'b0;
    mem_fault_clear = 1'b0;
    // Mid-run reset: answer, store strobe and memory status back to zero
    rst_b = 1'b0;
    u_pmtr_host_model.idle();
    u_pmtr_host_model.idle();
    chk({6'h00, rsp_valid, nvm_store_pulse, mem_status}, 16'h0000);
    chk(rsp_data, 16'h0000);
    // Write at the release edge is dropped; stored bytes reload
    rst_b = 1'b1;
    u_pmtr_host_model.send(1'b1, 8'h99, 16'h7700, rv, rd);
    chk({15'h0000, nvm_store_pulse}, 16'h0000);
    u_pmtr_host_model.send(1'b0, 8'h99, 16'h0000, rv, rd);
    chk(rd, 16'hc45a);
    u_pmtr_host_model.idle();
    end_sim();
  end

endmodule // pmtr_regs_tb_top

`default_nettype wire
